//--- logic/sdc_controller.sv
// SDRAM controller core with AXI4-Lite register slave.
// Summary of operation
// - No memory signal toggles until at least 200 us after reset.
// - Command mode 1: a memory write drives a NOP.
// - Command mode 2: a memory write drives all-banks precharge.
// - Command mode 4: each memory write drives one auto-refresh.
// - Command mode 3: a memory write drives load-mode-register.
// - Single and burst accesses; sequential same-row accesses stream on.
// - Row change or page boundary: precharge, activate, then command.
// - Insert programmed precharge and activate-to-command delays.
// - Read adds CAS latency of two cycles of wait.
// - End of row in burst forces automatic page break.
// - Periodic auto-refresh from timer reloaded by refresh count.
// - Missed refresh sets error flag; reading status clears it.
// - Memory access during refresh is stalled by bus wait.
// - Self-refresh request puts memory in self-refresh, clock enable low.
// - Next selection exits self-refresh and clears the request.
// - Self-refresh lasts at least the active-to-precharge delay.
// - Low-power: clock enable low when idle, refreshes continue, next access raises it.
// - Refresh error interrupt output goes to the system interrupt.
// - Bus width bit: 0 selects 32 bits, 1 selects 16 bits.
// - No periodic refresh until refresh count written once after reset.
// - Mode 3 places write offset on address lines as mode value.
`timescale 1ns/1ps
`default_nettype none
`include "sdc_defines.svh"
module sdc_controller #(
  parameter int PAUSE_CYCLES = `SDC_PAUSE_CYCLES
) (
  input  wire logic               core_clk,
  input  wire logic               nrst,
  input  wire logic [7:0]         s_axi_awaddr,
  input  wire logic               s_axi_awvalid,
  output logic                    s_axi_awready,
  input  wire logic [31:0]        s_axi_wdata,
  input  wire logic [3:0]         s_axi_wstrb,
  input  wire logic               s_axi_wvalid,
  output logic                    s_axi_wready,
  output logic [1:0]              s_axi_bresp,
  output logic                    s_axi_bvalid,
  input  wire logic               s_axi_bready,
  input  wire logic [7:0]         s_axi_araddr,
  input  wire logic               s_axi_arvalid,
  output logic                    s_axi_arready,
  output logic [31:0]             s_axi_rdata,
  output logic [1:0]              s_axi_rresp,
  output logic                    s_axi_rvalid,
  input  wire logic               s_axi_rready,
  input  wire sdc_pkg::sdc_memreq_type memReq,
  output logic                    bus_wait,
  output sdc_pkg::sdc_mempins_type memPins,
  output logic                    memIoEnable,
  output logic                    busWidth16,
  output logic                    irqOut
);
  import sdc_pkg::*;

  // Elaboration check: the pause counter needs at least one cycle.
  if (PAUSE_CYCLES < 1) begin : gBadPause
    $error("PAUSE_CYCLES must be at least one");
  end

  typedef enum logic [7:0] {
    ST_PAUSE  = 8'h01,
    ST_IDLE   = 8'h02,
    ST_PRE    = 8'h04,
    ST_ACT    = 8'h08,
    ST_CMD    = 8'h10,
    ST_CAS    = 8'h20,
    ST_REF    = 8'h40,
    ST_SELF   = 8'h80
  } sdc_state_type;

  // Saturate a timing field at the two-cycle floor.
  function automatic logic [3:0] floorDelay(input logic [3:0] f);
    floorDelay = (f <= `SDC_MIN_DELAY) ? `SDC_MIN_DELAY : f;
  endfunction : floorDelay

  ////////////////////////////////////////////////////////////////////////////
  // Register file.
  logic [31:0] modeReg_q;
  logic [11:0] refCount_q;
  logic        refWritten_q;
  logic [31:0] timing_q;
  logic        selfReq_q;
  logic        lowPower_q;
  logic        irqMask_q;
  logic        irqStat_q;
  logic        awHeld_q;
  logic        wHeld_q;
  logic [7:0]  awAddr_q;
  logic [31:0] wData_q;
  logic        wrFire;
  logic        rdFire;
  logic        refMiss;
  logic        selfExit;

  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_bresp   = 2'h0;
  assign s_axi_rresp   = 2'h0;
  assign wrFire = awHeld_q && wHeld_q;
  assign rdFire = s_axi_arvalid && s_axi_arready;

  // Address and data are latched independently so either may come first.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q <= 32'h00000000;
      s_axi_bvalid <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
      end
      if (wrFire) begin
        awHeld_q <= 1'b0;
        wHeld_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration writes; byte strobes are ignored, only the defined bits of each word are stored.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      modeReg_q <= `SDC_RST_MODE;
      refCount_q <= `SDC_RST_REFRESH;
      refWritten_q <= 1'b0;
      timing_q <= `SDC_RST_TIMING;
      lowPower_q <= 1'b0;
      irqMask_q <= 1'b0;
    end else if (wrFire) begin
      case (awAddr_q)
        `SDC_OFF_MODE: modeReg_q <= wData_q & 32'h0000001F;
        `SDC_OFF_REFRESH: begin
          refCount_q <= wData_q[11:0];
          refWritten_q <= 1'b1;
        end
        `SDC_OFF_TIMING: timing_q <= wData_q & 32'h7FFFFFFF;
        `SDC_OFF_LOWPOWER: lowPower_q <= wData_q[0];
        `SDC_OFF_IRQ_EN: irqMask_q <= irqMask_q | wData_q[`SDC_RFERR_BIT];
        `SDC_OFF_IRQ_DIS: irqMask_q <= irqMask_q & ~wData_q[`SDC_RFERR_BIT];
        default: ;
      endcase
    end
  end

  // Self-refresh request: set by software, cleared on exit.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      selfReq_q <= 1'b0;
    end else if (wrFire && awAddr_q == `SDC_OFF_SELFREF && wData_q[0]) begin
      selfReq_q <= 1'b1;
    end else if (selfExit) begin
      selfReq_q <= 1'b0;
    end
  end

  // Refresh error flag; a new miss in the reading cycle wins over the clear.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      irqStat_q <= 1'b0;
    end else if (refMiss) begin
      irqStat_q <= 1'b1;
    end else if (rdFire && s_axi_araddr == `SDC_OFF_IRQ_STAT) begin
      irqStat_q <= 1'b0;
    end
  end

  // Read data path; unmapped offsets read as zero with OKAY.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
    end else if (rdFire) begin
      s_axi_rvalid <= 1'b1;
      case (s_axi_araddr)
        `SDC_OFF_MODE: s_axi_rdata <= modeReg_q;
        `SDC_OFF_REFRESH: s_axi_rdata <= {20'h00000, refCount_q};
        `SDC_OFF_TIMING: s_axi_rdata <= timing_q;
        `SDC_OFF_LOWPOWER: s_axi_rdata <= {31'h00000000, lowPower_q};
        `SDC_OFF_IRQ_MASK: s_axi_rdata <= {31'h00000000, irqMask_q};
        `SDC_OFF_IRQ_STAT: s_axi_rdata <= {31'h00000000, irqStat_q};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  assign irqOut = irqStat_q & irqMask_q;
  assign busWidth16 = modeReg_q[`SDC_BUSW_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // Timing fields and geometry.
  logic [3:0]  tPre;
  logic [3:0]  tAct;
  logic [3:0]  active_to_precharge_delay;
  logic [3:0]  refresh_to_activate_delay;
  logic [3:0]  cmdMode;
  logic [3:0]  colBits;
  logic [27:0] offWord;
  logic [12:0] reqRow;
  logic [1:0]  reqBank;
  logic [10:0] reqCol;
  logic        lastCol;

  assign tPre = floorDelay(timing_q[`SDC_TRP_LSB +: 4]);
  assign tAct = floorDelay(timing_q[`SDC_ACTIVATE_TO_CMD_DELAY_LSB +: 4]);
  assign active_to_precharge_delay = floorDelay(timing_q[`SDC_ACTIVE_TO_PRECHARGE_DELAY_LSB +: 4]);
  assign refresh_to_activate_delay  = floorDelay(timing_q[`SDC_TRC_LSB +: 4]);
  assign cmdMode = modeReg_q[`SDC_MODE_LSB +: 4];
  assign colBits = 4'h8 + {2'h0, timing_q[`SDC_NC_LSB +: 2]};
  // Strip the byte lane bits: two for a 32-bit bus, one for 16 bits.
  assign offWord = busWidth16 ? {1'b0, memReq.addr[27:1]} : {2'h0, memReq.addr[27:2]};
  assign reqCol  = offWord[10:0] & ((11'h001 << colBits) - 11'h001);
  assign reqRow  = 13'(offWord >> colBits);
  assign reqBank = 2'(offWord >> (5'(colBits) + 5'h0D));
  assign lastCol = (reqCol == ((11'h001 << colBits) - 11'h001));

  ////////////////////////////////////////////////////////////////////////////
  // Refresh timer.
  logic [11:0] refTimer_q;
  logic        refPending_q;
  logic        refDone;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      refTimer_q <= 12'h000;
      refPending_q <= 1'b0;
    end else if (wrFire && awAddr_q == `SDC_OFF_REFRESH) begin
      // A new count restarts the interval at once, not after the old one expires.
      refTimer_q <= wData_q[11:0];
      refPending_q <= refPending_q && !refDone;
    end else if (!refWritten_q) begin
      refTimer_q <= refCount_q;
    end else if (refTimer_q == 12'h000) begin
      refTimer_q <= refCount_q;
      refPending_q <= 1'b1;
    end else begin
      refTimer_q <= refTimer_q - 12'h001;
      if (refDone) begin
        refPending_q <= 1'b0;
      end
    end
  end
  assign refMiss = refWritten_q && refTimer_q == 12'h000 && refPending_q && !refDone;

  ////////////////////////////////////////////////////////////////////////////
  // Command sequencer.
  sdc_state_type state_q;
  logic [15:0] wait_q;
  logic [31:0] pause_q;
  logic        rowOpen_q;
  logic [12:0] openRow_q;
  logic [1:0]  openBank_q;
  logic        curWrite_q;
  logic [10:0] curCol_q;
  sdc_mempins_type pins_q;
  logic        pageHit;
  logic        rowEnd_q;

  assign pageHit = rowOpen_q && !rowEnd_q && openRow_q == reqRow && openBank_q == reqBank;
  assign refDone = state_q == ST_REF && wait_q == 16'h0000;
  assign selfExit = state_q == ST_SELF && memReq.valid && wait_q == 16'h0000;
  assign bus_wait = memReq.valid && !(state_q == ST_IDLE && !refPending_q
                    && (cmdMode != 4'h0 || pageHit));
  assign memPins = pins_q;
  // Buffers follow clock enable, so they never wake ahead of the memory.
  assign memIoEnable = pins_q.clkEn;

  // One-cycle memory commands are encoded {cs, ras, cas, we} active low.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= ST_PAUSE;
      wait_q <= 16'h0000;
      pause_q <= 32'h00000000;
      rowOpen_q <= 1'b0;
      openRow_q <= 13'h0000;
      openBank_q <= 2'h0;
      curWrite_q <= 1'b0;
      curCol_q <= 11'h000;
      rowEnd_q <= 1'b0;
      pins_q <= {1'b1, 4'hF, 2'h0, 13'h0000};
    end else begin
      pins_q.csN <= 1'b1;
      pins_q.rasN <= 1'b1;
      pins_q.casN <= 1'b1;
      pins_q.weN <= 1'b1;
      if (wait_q != 16'h0000) begin
        wait_q <= wait_q - 16'h0001;
      end
      case (state_q)
        ST_PAUSE: begin
          pins_q.csN <= 1'b1;
          if (pause_q == 32'(PAUSE_CYCLES - 1)) begin
            state_q <= ST_IDLE;
          end else begin
            pause_q <= pause_q + 32'h00000001;
          end
        end
        ST_IDLE: begin
          pins_q.clkEn <= !(lowPower_q && !memReq.valid && !refPending_q);
          if (refPending_q) begin
            pins_q.clkEn <= 1'b1;
            // The refresh itself is issued only from its own state, once per request.
            state_q <= rowOpen_q ? ST_PRE : ST_REF;
          end else if (selfReq_q && !memReq.valid) begin
            {pins_q.csN, pins_q.rasN, pins_q.casN, pins_q.weN} <= 4'h1;
            pins_q.clkEn <= 1'b0;
            rowOpen_q <= 1'b0;
            wait_q <= {12'h000, active_to_precharge_delay};
            state_q <= ST_SELF;
          end else if (memReq.valid && cmdMode != 4'h0) begin
            pins_q.clkEn <= 1'b1;
            case (cmdMode)
              4'h1: {pins_q.csN, pins_q.rasN, pins_q.casN, pins_q.weN} <= 4'h7;
              4'h2: begin
                {pins_q.csN, pins_q.rasN, pins_q.casN, pins_q.weN} <= 4'h2;
                pins_q.addr <= 13'h0400;
                rowOpen_q <= 1'b0;
              end
              4'h3: begin
                {pins_q.csN, pins_q.rasN, pins_q.casN, pins_q.weN} <= 4'h0;
                pins_q.addr <= memReq.addr[12:0];
                pins_q.bank <= memReq.addr[14:13];
              end
              4'h4: {pins_q.csN, pins_q.rasN, pins_q.casN, pins_q.weN} <= 4'h1;
              default: {pins_q.csN, pins_q.rasN, pins_q.casN, pins_q.weN} <= 4'h7;
            endcase
          end else if (memReq.valid) begin
            pins_q.clkEn <= 1'b1;
            curWrite_q <= memReq.write;
            curCol_q <= reqCol;
            if (pageHit) begin
              {pins_q.csN, pins_q.rasN, pins_q.casN} <= 3'h2;
              pins_q.weN <= !memReq.write;
              pins_q.addr <= {2'h0, reqCol};
              // Force page break; the row stays open so it is precharged.
              rowEnd_q <= lastCol;
              if (!memReq.write) begin
                wait_q <= {12'h000, `SDC_CAS_CYCLES};
                state_q <= ST_CAS;
              end
            end else begin
              state_q <= rowOpen_q ? ST_PRE : ST_ACT;
            end
          end
        end
        ST_PRE: begin
          if (wait_q == 16'h0000) begin
            {pins_q.csN, pins_q.rasN, pins_q.casN, pins_q.weN} <= 4'h2;
            pins_q.addr <= 13'h0400;
            rowOpen_q <= 1'b0;
            wait_q <= {12'h000, tPre};
            state_q <= refPending_q ? ST_REF : ST_ACT;
          end
        end
        ST_ACT: begin
          if (wait_q == 16'h0000) begin
            {pins_q.csN, pins_q.rasN, pins_q.casN, pins_q.weN} <= 4'h3;
            pins_q.addr <= reqRow;
            pins_q.bank <= reqBank;
            openRow_q <= reqRow;
            openBank_q <= reqBank;
            rowOpen_q <= 1'b1;
            rowEnd_q <= 1'b0;
            wait_q <= {12'h000, tAct};
            state_q <= ST_CMD;
          end
        end
        ST_CMD: begin
          if (wait_q == 16'h0000) begin
            state_q <= ST_IDLE;
          end
        end
        ST_CAS: begin
          if (wait_q == 16'h0000) begin
            state_q <= ST_IDLE;
          end
        end
        ST_REF: begin
          if (wait_q == 16'h0001 && !pins_q.csN) begin
            wait_q <= 16'h0000;
          end
          if (wait_q == 16'h0000 && pins_q.csN && pins_q.rasN) begin
            {pins_q.csN, pins_q.rasN, pins_q.casN, pins_q.weN} <= 4'h1;
            wait_q <= {12'h000, refresh_to_activate_delay};
            state_q <= ST_CMD;
          end
        end
        ST_SELF: begin
          pins_q.clkEn <= 1'b0;
          if (memReq.valid && wait_q == 16'h0000) begin
            pins_q.clkEn <= 1'b1;
            wait_q <= {12'h000, refresh_to_activate_delay};
            state_q <= ST_CMD;
          end
        end
        default: state_q <= ST_IDLE;
      endcase
    end
  end
endmodule : sdc_controller
`default_nettype wire

//--- include/sdc_defines.svh
// Offsets, field positions, reset values and timing counts of the SDRAM controller.
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH
`define SDC_OFF_MODE      8'h00
`define SDC_OFF_REFRESH   8'h04
`define SDC_OFF_TIMING    8'h08
`define SDC_OFF_SELFREF   8'h0C
`define SDC_OFF_LOWPOWER  8'h10
`define SDC_OFF_IRQ_EN    8'h14
`define SDC_OFF_IRQ_DIS   8'h18
`define SDC_OFF_IRQ_MASK  8'h1C
`define SDC_OFF_IRQ_STAT  8'h20
`define SDC_RST_MODE      32'h00000010
`define SDC_RST_REFRESH   12'h800
`define SDC_RST_TIMING    32'h2A99C140
`define SDC_MODE_LSB      0
`define SDC_BUSW_BIT      4
`define SDC_NC_LSB        0
`define SDC_NR_LSB        2
`define SDC_TRC_LSB       11
`define SDC_TRP_LSB       15
`define SDC_ACTIVATE_TO_CMD_DELAY_LSB      19
`define SDC_ACTIVE_TO_PRECHARGE_DELAY_LSB      23
`define SDC_RFERR_BIT     0
`define SDC_MIN_DELAY     4'h2
`define SDC_CAS_CYCLES    4'h2
`define SDC_PAUSE_US      200
`define SDC_CLK_MHZ       20
`define SDC_PAUSE_CYCLES  (`SDC_PAUSE_US * `SDC_CLK_MHZ)
`endif

//--- include/sdc_pkg.sv
// Types shared by the SDRAM controller.
package sdc_pkg;
  typedef enum logic [3:0] {
    SDC_CMD_NORMAL  = 4'h0,
    SDC_CMD_NOP     = 4'h1,
    SDC_CMD_PRECALL = 4'h2,
    SDC_CMD_LOADMR  = 4'h3,
    SDC_CMD_REFRESH = 4'h4
  } sdc_cmdmode_type;
  // Memory-side pin group: cs, ras, cas, we are active low.
  typedef struct packed {
    logic        clkEn;
    logic        csN;
    logic        rasN;
    logic        casN;
    logic        weN;
    logic [1:0]  bank;
    logic [12:0] addr;
  } sdc_mempins_type;
  // System-bus memory request.
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        seq;
    logic [27:0] addr;
  } sdc_memreq_type;
endpackage : sdc_pkg

//--- bench/sdc_props.sv
// Concurrent checks on the ports of the SDRAM controller.
`timescale 1ns/1ps
`default_nettype none
module sdc_props #(
  parameter int PAUSE_CYCLES = 10
) (
  input wire logic                     core_clk,
  input wire logic                     nrst,
  input wire logic                     s_axi_awready,
  input wire logic                     s_axi_wready,
  input wire logic [1:0]               s_axi_bresp,
  input wire logic                     s_axi_bvalid,
  input wire logic                     s_axi_bready,
  input wire logic                     s_axi_arready,
  input wire logic [31:0]              s_axi_rdata,
  input wire logic                     s_axi_rvalid,
  input wire logic                     s_axi_rready,
  input wire sdc_pkg::sdc_memreq_type  memReq,
  input wire sdc_pkg::sdc_mempins_type memPins,
  input wire logic                     memIoEnable
);
  import sdc_pkg::*;
  int unsigned pauseCnt;
  logic [2:0]  rcw;
  logic        isAct;
  logic        isPre;
  logic        isRw;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  ////////////////////////////////////////////////////////////////////////////////
  // Command decode from the active-low strobes.
  assign rcw = {memPins.rasN, memPins.casN, memPins.weN};
  assign isAct = !memPins.csN && rcw == 3'b011;
  assign isPre = !memPins.csN && rcw == 3'b010;
  assign isRw = !memPins.csN && rcw[2:1] == 2'b10;
  // Cycles since reset release; saturates so it never wraps in long runs.
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pauseCnt <= 0;
    end else if (pauseCnt < PAUSE_CYCLES) begin
      pauseCnt <= pauseCnt + 1;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  pause_quiet_a: assert property (pauseCnt < PAUSE_CYCLES |-> $stable(memPins))
    else $error("Memory pins moved during the power-up pause.");
  act_to_cmd_a: assert property (isAct |=> !isRw)
    else $error("Read or write too soon after activate.");
  pre_to_act_a: assert property (isPre |=> !isAct)
    else $error("Activate too soon after precharge.");
  sr_min_hold_a: assert property ($fell(memPins.clkEn) && !memPins.csN
                                  |=> !memPins.clkEn)
    else $error("Clock enable low for under two cycles.");
  idle_io_off_a: assert property (!memPins.clkEn && !memReq.valid |-> !memIoEnable)
    else $error("Buffers on while clock enable low and idle.");
  bresp_okay_a: assert property (s_axi_bvalid |-> s_axi_bresp == 2'b00) // Bus response.
    else $error("Write response not okay.");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid) // Bus hold.
    else $error("Write response dropped early.");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata)) // Bus hold.
    else $error("Read data dropped or changed early.");
  wr_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready) // One write.
    else $error("Write accepted while response pending.");
  rd_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready) // One read.
    else $error("Read accepted while data pending.");
  // Main scenarios reached.
  cover property (isAct ##[2:20] isRw);
  cover property ($fell(memPins.clkEn));
  cover property (isPre ##[2:20] isAct);
endmodule : sdc_props
bind sdc_controller sdc_props #(.PAUSE_CYCLES(PAUSE_CYCLES)) props_u (
  .core_clk, .nrst, .s_axi_awready, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready,
  .memReq, .memPins, .memIoEnable);
`default_nettype wire

//--- bench/sdc_sdram_model.sv
// Behavioural SDR SDRAM that classifies and counts the commands it receives.
`timescale 1ns/1ps
`default_nettype none
module sdc_sdram_model (
  input wire logic                     core_clk,
  input wire logic                     nrst,
  input wire sdc_pkg::sdc_mempins_type memPins
);
  import sdc_pkg::*;
  int          nopCnt, preCnt, actCnt, rdCnt, wrCnt, refCnt, lmrCnt;
  logic [12:0] preAddr;
  logic [12:0] lmrAddr;
  // Command decode.
  // Commands with clock enable low are ignored, as the device would.
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      {nopCnt, preCnt, actCnt, rdCnt, wrCnt, refCnt, lmrCnt} = '0;
    end else if (memPins.clkEn && !memPins.csN) begin
      case ({memPins.rasN, memPins.casN, memPins.weN})
        3'b111: nopCnt++;
        3'b011: actCnt++;
        3'b101: rdCnt++;
        3'b100: wrCnt++;
        3'b001: refCnt++;
        3'b010: begin
          preCnt++;
          preAddr = memPins.addr;
        end
        default: begin
          lmrCnt++;
          lmrAddr = memPins.addr;
        end
      endcase
    end
  end
endmodule : sdc_sdram_model
`default_nettype wire

//--- bench/sdram_controller_core_tb.sv
// Self-checking bench: register access and memory command sequences.
`timescale 1ns/1ps
`default_nettype none
module sdram_controller_core_tb;
  import sdc_pkg::*;
  logic            core_clk, nrst, busWidth16, irqOut, bus_wait, memIoEnable;
  logic [7:0]      s_axi_awaddr, s_axi_araddr;
  logic [31:0]     s_axi_wdata, s_axi_rdata;
  logic [1:0]      s_axi_bresp, s_axi_rresp;
  logic            s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic            s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic            s_axi_rvalid, s_axi_rready;
  sdc_memreq_type  memReq;
  sdc_mempins_type memPins;
  int              errCount, nTests, cyc;
  logic [7:0]      offs [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h1C, 8'h20};
  logic [31:0]     rsts [6] = '{32'h10, 32'h800, 32'h2A99C140, 32'h0, 32'h0, 32'h0};
  // Short pause keeps the run brief; the sequencer counts it in cycles.
  sdc_controller #(.PAUSE_CYCLES(10)) dut_u (.core_clk, .nrst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .memReq,
    .bus_wait, .memPins, .memIoEnable, .busWidth16, .irqOut);
  sdc_sdram_model model_u (.core_clk, .nrst, .memPins);
  ////////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard.
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 12000) begin
      errCount++;
      tallyAndFinish();
    end
  end
  task automatic tallyAndFinish();
    if (errCount == 0 && nTests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tallyAndFinish
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    nTests++;
    if (got !== exp) begin
      errCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Write: address and data offered together, each released once taken.
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (!aw && s_axi_awready === 1'b1) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!w && s_axi_wready === 1'b1) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask : axiWr
  task automatic axiRd(input logic [7:0] a, output logic [31:0] d);
    logic ar;
    ar = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      if (!ar && s_axi_arready === 1'b1) begin
        ar = 1'b1;
        s_axi_arvalid <= 1'b0;
      end
    end while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask : axiRd
  // Memory request held until an edge sees it with bus wait low.
  task automatic memAcc(input logic wr, input logic [27:0] a, input logic sq);
    @(posedge core_clk);
    memReq <= '{1'b1, wr, sq, a};
    do @(posedge core_clk); while (bus_wait !== 1'b0);
    memReq.valid <= 1'b0;
  endtask : memAcc
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] d;
    int          n0;
    int          low;
    {core_clk, nrst, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {memReq, errCount, nTests, cyc} = '0;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      axiRd(offs[i], d);
      chk(d, rsts[i]);
    end
    chk(32'(busWidth16), 32'h1);
    axiWr(8'h40, 32'hFFFFFFFF);
    axiRd(8'h40, d);
    chk(d, 32'h0);
    // No refresh before the timer write.
    repeat (2200) @(posedge core_clk);
    chk(model_u.refCnt, 32'h0);
    axiWr(8'h00, 32'h1);
    chk(32'(busWidth16), 32'h0);
    memAcc(1'b1, 28'h0, 1'b0);
    axiWr(8'h00, 32'h2);
    memAcc(1'b1, 28'h0, 1'b0);
    axiWr(8'h00, 32'h4);
    repeat (8) memAcc(1'b1, 28'h0, 1'b0);
    axiWr(8'h00, 32'h3);
    memAcc(1'b1, 28'h31, 1'b0);
    axiWr(8'h00, 32'h0);
    memAcc(1'b1, 28'h0, 1'b0);
    repeat (40) @(posedge core_clk);
    chk(32'(model_u.nopCnt != 0), 32'h1);
    chk(32'(model_u.preAddr[10]), 32'h1);
    chk(model_u.refCnt, 32'h8);
    chk(32'(model_u.lmrAddr), 32'h31);
    chk(model_u.actCnt + model_u.wrCnt, 32'h2);
    // Hit, row change, then end-of-row crossing.
    memAcc(1'b0, 28'h4, 1'b1);
    memAcc(1'b0, 28'h100000, 1'b0);
    memAcc(1'b0, 28'h1003FC, 1'b0);
    memAcc(1'b0, 28'h100400, 1'b1);
    repeat (40) @(posedge core_clk);
    chk(model_u.actCnt, 32'h3);
    chk(model_u.preCnt, 32'h3);
    chk(model_u.rdCnt, 32'h4);
    // Periodic refresh at the programmed interval.
    axiWr(8'h04, 32'd100);
    n0 = model_u.refCnt;
    repeat (350) @(posedge core_clk);
    chk(32'((model_u.refCnt - n0) inside {[3:4]}), 32'h1);
    // Mask set and read back, status quiet.
    axiWr(8'h14, 32'h1);
    axiRd(8'h1C, d);
    chk(d, 32'h1);
    axiRd(8'h20, d);
    chk(d, 32'h0);
    chk(32'(irqOut), 32'h0);
    // A three-cycle interval (count of 2) cannot be met, so misses are flagged.
    axiWr(8'h04, 32'd2);
    repeat (30) @(posedge core_clk);
    chk(32'(irqOut), 32'h1);
    axiWr(8'h04, 32'd100);
    axiRd(8'h20, d);
    chk(d, 32'h1);
    axiRd(8'h20, d);
    chk(d, 32'h0);
    axiWr(8'h18, 32'h1);
    axiRd(8'h1C, d);
    chk(d, 32'h0);
    // Self-refresh entry and exit by access.
    axiWr(8'h0C, 32'h1);
    repeat (20) @(posedge core_clk);
    chk({memPins.clkEn, memIoEnable}, 32'h0);
    n0 = model_u.rdCnt;
    memAcc(1'b0, 28'h0, 1'b0);
    repeat (100) @(posedge core_clk);
    chk(32'(memPins.clkEn), 32'h1);
    chk(model_u.rdCnt - n0, 32'h1);
    // Low-power: idle clock enable low, refresh continues.
    axiWr(8'h10, 32'h1);
    axiRd(8'h10, d);
    chk(d, 32'h1);
    n0 = model_u.refCnt;
    low = 0;
    repeat (350) begin
      @(posedge core_clk);
      if (memPins.clkEn === 1'b0) low++;
    end
    chk(32'(low > 200), 32'h1);
    chk(32'(model_u.refCnt - n0 >= 3), 32'h1);
    n0 = model_u.wrCnt;
    memAcc(1'b1, 28'h8, 1'b0);
    repeat (40) @(posedge core_clk);
    chk(model_u.wrCnt - n0, 32'h1);
    axiWr(8'h10, 32'h0);
    tallyAndFinish();
  end
endmodule : sdram_controller_core_tb
`default_nettype wire
